// File: dpgc_top.v
// Dedicated-pin GPIO select and card-pin direction control, AXI4-Lite slave.
// Assumes the card-pin GPIO mode select and the pin data registers live elsewhere
// on the same clock; card pad inputs arrive asynchronously from the pads.
//
// Behaviour
// [R1] Select register at 0x64; bits 31:22 and 15:8 read zero.
// [R2] Bit 21 puts the suspend pin into GPIO mode; resets to zero.
// [R3] Bits 19:16 put each wake pin into GPIO mode; reset to zero.
// [R4] Bits 7:0 put each dedicated pin into GPIO mode; reset 8'hdf; dedicated_pins_gpio_o holds 8'h00 while reset is held.
// [R5] Direction register at 0x68; bits 7:0 read-write reset zero, rest zero.
// [R6] Direction bits 7:4 steer card data pins 7:4 in GPIO mode.
// [R7] Direction bits 3:0 steer card data pins 3:0 in GPIO mode.
// [R8] GPIO mode with direction zero: pin is an input, not driven.
// [R9] GPIO mode with direction one: pin is driven as output.
// [R10] Outside GPIO mode the direction bit has no effect on the pin.
// [R11] Writes change only read-write bits; reads show zeros elsewhere.
// [R12] Driver enabled only in GPIO mode with direction one, else function's enable.
`timescale 1ns/100ps
`include "dpgc_defs.vh"
module dpgc_top #(
  parameter CARD_W = 8
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [11:0] s_axil_awaddr_i,
  input wire [2:0] s_axil_awprot_i,
  input wire s_axil_awvalid_i,
  output reg s_axil_awready_o,
  input wire [31:0] s_axil_wdata_i,
  input wire [3:0] s_axil_wstrb_i,
  input wire s_axil_wvalid_i,
  output reg s_axil_wready_o,
  output reg [1:0] s_axil_bresp_o,
  output reg s_axil_bvalid_o,
  input wire s_axil_bready_i,
  input wire [11:0] s_axil_araddr_i,
  input wire [2:0] s_axil_arprot_i,
  input wire s_axil_arvalid_i,
  output reg s_axil_arready_o,
  output reg [31:0] s_axil_rdata_o,
  output reg [1:0] s_axil_rresp_o,
  output reg s_axil_rvalid_o,
  input wire s_axil_rready_i,
  output reg suspend_domain_pin_gpio_o,
  output reg [3:0] wake_input_pins_gpio_o,
  output reg [7:0] dedicated_pins_gpio_o,
  input wire [CARD_W-1:0] card_data_gpio_mode_i,
  input wire [CARD_W-1:0] card_data_gpio_dout_i,
  input wire [CARD_W-1:0] card_data_func_out_i,
  input wire [CARD_W-1:0] card_data_func_oe_i,
  input wire [CARD_W-1:0] card_data_pad_i,
  output wire [CARD_W-1:0] card_data_pad_o,
  output wire [CARD_W-1:0] card_data_pad_oe_o,
  output wire [CARD_W-1:0] card_data_din_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage.

  reg [31:0] sel_reg;
  reg [31:0] sel_next;
  reg [31:0] dir_reg;
  reg [31:0] dir_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are caught independently, then committed.

  reg aw_held_reg;
  reg w_held_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire wr_commit;
  wire [31:0] byte_mask;
  wire [11:0] wr_word;
  wire wr_sel_hit;
  wire wr_dir_hit;

  assign wr_commit = aw_held_reg && w_held_reg && !s_axil_bvalid_o;
  assign byte_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                      {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  // Low address bits are dropped so any byte address in a word selects it.
  assign wr_word = {awaddr_reg[11:2], 2'b00};
  assign wr_sel_hit = (wr_word == `DPGC_SEL_OFF);
  assign wr_dir_hit = (wr_word == `DPGC_DIR_OFF);

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_axil_awready_o <= 1'b1;
      s_axil_wready_o <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axil_bvalid_o <= 1'b0;
      s_axil_bresp_o <= `DPGC_RESP_OKAY;
    end else begin
      if (s_axil_awvalid_i && s_axil_awready_o) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axil_awaddr_i;
        s_axil_awready_o <= 1'b0;
      end else if (s_axil_bvalid_o && s_axil_bready_i) begin
        s_axil_awready_o <= 1'b1;
      end
      if (s_axil_wvalid_i && s_axil_wready_o) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axil_wdata_i;
        wstrb_reg <= s_axil_wstrb_i;
        s_axil_wready_o <= 1'b0;
      end else if (s_axil_bvalid_o && s_axil_bready_i) begin
        s_axil_wready_o <= 1'b1;
      end
      if (wr_commit) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axil_bvalid_o <= 1'b1;
        s_axil_bresp_o <= (wr_sel_hit || wr_dir_hit) ? `DPGC_RESP_OKAY : `DPGC_RESP_SLVERR;
      end else if (s_axil_bvalid_o && s_axil_bready_i) begin
        s_axil_bvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register update with byte strobes; read-only positions never store.

  always @* begin
    sel_next = sel_reg;
    dir_next = dir_reg;
    if (wr_commit && wr_sel_hit) begin
      sel_next = ((sel_reg & ~byte_mask) | (wdata_reg & byte_mask))
                 & `DPGC_SEL_RW_MASK; // [R1] [R11]
    end
    if (wr_commit && wr_dir_hit) begin
      dir_next = ((dir_reg & ~byte_mask) | (wdata_reg & byte_mask))
                 & `DPGC_DIR_RW_MASK; // [R5] [R11]
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sel_reg <= `DPGC_SEL_RESET; // [R2] [R3] [R4]
      dir_reg <= `DPGC_DIR_RESET; // [R5]
    end else begin
      sel_reg <= sel_next;
      dir_reg <= dir_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address acceptance to data.

  wire [11:0] rd_word;
  assign rd_word = {s_axil_araddr_i[11:2], 2'b00};

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_axil_arready_o <= 1'b1;
      s_axil_rvalid_o <= 1'b0;
      s_axil_rdata_o <= 32'h00000000;
      s_axil_rresp_o <= `DPGC_RESP_OKAY;
    end else if (s_axil_arvalid_i && s_axil_arready_o) begin
      s_axil_arready_o <= 1'b0;
      s_axil_rvalid_o <= 1'b1;
      if (rd_word == `DPGC_SEL_OFF) begin
        s_axil_rdata_o <= sel_reg & `DPGC_SEL_RW_MASK; // [R1] [R11]
        s_axil_rresp_o <= `DPGC_RESP_OKAY;
      end else if (rd_word == `DPGC_DIR_OFF) begin
        s_axil_rdata_o <= dir_reg & `DPGC_DIR_RW_MASK; // [R5] [R11]
        s_axil_rresp_o <= `DPGC_RESP_OKAY;
      end else begin
        s_axil_rdata_o <= 32'h00000000;
        s_axil_rresp_o <= `DPGC_RESP_SLVERR;
      end
    end else if (s_axil_rvalid_o && s_axil_rready_i) begin
      s_axil_rvalid_o <= 1'b0;
      s_axil_arready_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Function selects for the suspend, wake and dedicated pins.

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      suspend_domain_pin_gpio_o <= 1'b0;
      wake_input_pins_gpio_o <= 4'h0;
      dedicated_pins_gpio_o <= 8'h00;
    end else begin
      // One cycle behind the register so every output leaves a flop.
      suspend_domain_pin_gpio_o <= sel_reg[`DPGC_SUSP_BIT]; // [R2]
      wake_input_pins_gpio_o <= sel_reg[`DPGC_WAKE_MSB:`DPGC_WAKE_LSB]; // [R3]
      dedicated_pins_gpio_o <= sel_reg[`DPGC_DED_MSB:`DPGC_DED_LSB]; // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Card data pins: direction bit n steers pin n, upper and lower halves alike.

  wire [CARD_W-1:0] card_dir;
  assign card_dir = dir_reg[CARD_W-1:0]; // [R6] [R7]

  dpgc_card_pad #(
    .WIDTH(CARD_W)
  ) u_card_pad (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .gpio_mode_i(card_data_gpio_mode_i),
    .gpio_dir_i(card_dir),
    .gpio_dout_i(card_data_gpio_dout_i),
    .func_out_i(card_data_func_out_i),
    .func_oe_i(card_data_func_oe_i),
    .pad_o(card_data_pad_o),
    .pad_oe_o(card_data_pad_oe_o)
  );

  // Pad levels are asynchronous; they are only seen after two flops.
  dpgc_sync2 #(
    .WIDTH(CARD_W)
  ) u_card_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i(card_data_pad_i),
    .sync_o(card_data_din_o)
  );

endmodule // dpgc_top

// File: dpgc_defs.vh
// Constants for the dedicated-pin and card-pin GPIO control block.
// Included by the top design file of the block; holds definitions only.
`ifndef DPGC_DEFS_VH
`define DPGC_DEFS_VH

`define DPGC_ADDR_W 12
`define DPGC_SEL_OFF 12'h064
`define DPGC_DIR_OFF 12'h068

`define DPGC_SEL_RW_MASK 32'h003f00ff
`define DPGC_SEL_RESET 32'h000000df
`define DPGC_DIR_RW_MASK 32'h000000ff
`define DPGC_DIR_RESET 32'h00000000

`define DPGC_SUSP_BIT 21
`define DPGC_WAKE_MSB 19
`define DPGC_WAKE_LSB 16
`define DPGC_DED_MSB 7
`define DPGC_DED_LSB 0
`define DPGC_DIR_MSB 7
`define DPGC_DIR_LSB 0

`define DPGC_RESP_OKAY 2'b00
`define DPGC_RESP_SLVERR 2'b10

`endif

// File: dpgc_sync2.v
// Two-flop synchroniser for a bus of independent pad levels.
// Assumes each bit is a slow level; no word coherence across bits.
`timescale 1ns/100ps
module dpgc_sync2 #(
  parameter WIDTH = 8
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule // dpgc_sync2

// File: dpgc_card_pad.v
// Per-pin pad steering for the card data pins.
// Assumes mode, direction and function signals all come from the system clock domain.
`timescale 1ns/100ps
module dpgc_card_pad #(
  parameter WIDTH = 8
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [WIDTH-1:0] gpio_mode_i,
  input wire [WIDTH-1:0] gpio_dir_i,
  input wire [WIDTH-1:0] gpio_dout_i,
  input wire [WIDTH-1:0] func_out_i,
  input wire [WIDTH-1:0] func_oe_i,
  output reg [WIDTH-1:0] pad_o,
  output reg [WIDTH-1:0] pad_oe_o
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          pad_o[i] <= 1'b0;
          pad_oe_o[i] <= 1'b0;
        end else if (gpio_mode_i[i]) begin
          // Direction one drives, zero leaves the pad as an input.
          pad_oe_o[i] <= gpio_dir_i[i]; // [R8] [R9] [R12]
          pad_o[i] <= gpio_dout_i[i];
        end else begin
          // The direction bit is ignored outside GPIO mode.
          pad_oe_o[i] <= func_oe_i[i]; // [R10] [R12]
          pad_o[i] <= func_out_i[i];
        end
      end
    end
  endgenerate

endmodule // dpgc_card_pad

// File: dpgc_top_properties.sv
// Assertions for the GPIO select and card-pin block.
// Bound to dpgc_top; watches its ports only, one clock domain.
`timescale 1ns/100ps
module dpgc_chk #(
  parameter CARD_W = 8
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire s_axil_awvalid_i,
  input wire s_axil_awready_o,
  input wire s_axil_wvalid_i,
  input wire s_axil_wready_o,
  input wire s_axil_bvalid_o,
  input wire s_axil_bready_i,
  input wire [1:0] s_axil_bresp_o,
  input wire s_axil_arvalid_i,
  input wire s_axil_arready_o,
  input wire s_axil_rvalid_o,
  input wire s_axil_rready_i,
  input wire [31:0] s_axil_rdata_o,
  input wire [7:0] dedicated_pins_gpio_o,
  input wire [CARD_W-1:0] card_data_gpio_mode_i,
  input wire [CARD_W-1:0] card_data_gpio_dout_i,
  input wire [CARD_W-1:0] card_data_func_oe_i,
  input wire [CARD_W-1:0] card_data_pad_o,
  input wire [CARD_W-1:0] card_data_pad_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence wr_both;
    s_axil_awvalid_i && s_axil_awready_o && s_axil_wvalid_i && s_axil_wready_o;
  endsequence
  sequence rd_take;
    s_axil_arvalid_i && s_axil_arready_o;
  endsequence
  wr_resp_a:
    assert property (wr_both |-> ##2 s_axil_bvalid_o) else $error("late bvalid");
  b_hold_a:
    assert property (s_axil_bvalid_o && !s_axil_bready_i |=> s_axil_bvalid_o
      && $stable(s_axil_bresp_o)) else $error("b dropped");
  rd_resp_a:
    assert property (rd_take |=> s_axil_rvalid_o) else $error("late rvalid");
  r_hold_a:
    assert property (s_axil_rvalid_o && !s_axil_rready_i |=> s_axil_rvalid_o
      && $stable(s_axil_rdata_o)) else $error("r dropped");
  ar_block_a:
    assert property (s_axil_rvalid_o |-> !s_axil_arready_o) else $error("ar open");
  rsvd_zero_a:
    assert property (s_axil_rvalid_o |-> (s_axil_rdata_o & 32'hffc0ff00) == 32'h0)
      else $error("reserved bits set");
  ded_reset_a:
    assert property ($fell(sys_rst_i) |=> dedicated_pins_gpio_o == 8'hdf)
      else $error("bad select reset");
  // The first edge after reset still sees the pre-reset inputs through past.
  func_oe_a:
    assert property (!$past(sys_rst_i) |-> ((card_data_pad_oe_o ^ $past(card_data_func_oe_i))
      & ~$past(card_data_gpio_mode_i)) == '0) else $error("oe not function");
  gpio_out_a:
    assert property (!$past(sys_rst_i) |-> ((card_data_pad_o ^ $past(card_data_gpio_dout_i))
      & card_data_pad_oe_o & $past(card_data_gpio_mode_i)) == '0) else $error("bad dout");
endmodule // dpgc_chk
bind dpgc_top dpgc_chk #(.CARD_W(CARD_W)) u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .s_axil_awvalid_i(s_axil_awvalid_i), .s_axil_awready_o(s_axil_awready_o),
  .s_axil_wvalid_i(s_axil_wvalid_i), .s_axil_wready_o(s_axil_wready_o),
  .s_axil_bvalid_o(s_axil_bvalid_o), .s_axil_bready_i(s_axil_bready_i),
  .s_axil_bresp_o(s_axil_bresp_o), .s_axil_arvalid_i(s_axil_arvalid_i),
  .s_axil_arready_o(s_axil_arready_o), .s_axil_rvalid_o(s_axil_rvalid_o),
  .s_axil_rready_i(s_axil_rready_i), .s_axil_rdata_o(s_axil_rdata_o),
  .dedicated_pins_gpio_o(dedicated_pins_gpio_o),
  .card_data_gpio_mode_i(card_data_gpio_mode_i),
  .card_data_gpio_dout_i(card_data_gpio_dout_i),
  .card_data_func_oe_i(card_data_func_oe_i),
  .card_data_pad_o(card_data_pad_o),
  .card_data_pad_oe_o(card_data_pad_oe_o)
);

// File: testbench.sv
// Self-checking bench for dpgc_top.
// Drives the AXI4-Lite port and card pad inputs directly.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s expected %h seen %h", n, e, g); end end
module testbench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] s_axil_awaddr_i = '0, s_axil_araddr_i = '0;
  logic [2:0] s_axil_awprot_i = '0, s_axil_arprot_i = '0;
  logic [31:0] s_axil_wdata_i = '0;
  logic [3:0] s_axil_wstrb_i = 4'hf;
  logic s_axil_awvalid_i = 1'b0, s_axil_wvalid_i = 1'b0, s_axil_bready_i = 1'b0;
  logic s_axil_arvalid_i = 1'b0, s_axil_rready_i = 1'b0;
  logic [7:0] card_data_gpio_mode_i = '0, card_data_gpio_dout_i = '0, card_data_pad_i = '0;
  logic [7:0] card_data_func_out_i = '0, card_data_func_oe_i = '0;
  wire s_axil_awready_o, s_axil_wready_o, s_axil_bvalid_o, s_axil_arready_o, s_axil_rvalid_o;
  wire [1:0] s_axil_bresp_o, s_axil_rresp_o;
  wire [31:0] s_axil_rdata_o;
  wire suspend_domain_pin_gpio_o;
  wire [3:0] wake_input_pins_gpio_o;
  wire [7:0] dedicated_pins_gpio_o, card_data_pad_o, card_data_pad_oe_o, card_data_din_o;
  wire [12:0] sel_pins = {suspend_domain_pin_gpio_o, wake_input_pins_gpio_o,
    dedicated_pins_gpio_o};
  int mismatches = 0, cmp_count = 0, cyc = 0;
  dpgc_top #(.CARD_W(8)) dut_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .s_axil_awaddr_i(s_axil_awaddr_i), .s_axil_awprot_i(s_axil_awprot_i),
    .s_axil_awvalid_i(s_axil_awvalid_i), .s_axil_awready_o(s_axil_awready_o),
    .s_axil_wdata_i(s_axil_wdata_i), .s_axil_wstrb_i(s_axil_wstrb_i),
    .s_axil_wvalid_i(s_axil_wvalid_i), .s_axil_wready_o(s_axil_wready_o),
    .s_axil_bresp_o(s_axil_bresp_o), .s_axil_bvalid_o(s_axil_bvalid_o),
    .s_axil_bready_i(s_axil_bready_i),
    .s_axil_araddr_i(s_axil_araddr_i), .s_axil_arprot_i(s_axil_arprot_i),
    .s_axil_arvalid_i(s_axil_arvalid_i), .s_axil_arready_o(s_axil_arready_o),
    .s_axil_rdata_o(s_axil_rdata_o), .s_axil_rresp_o(s_axil_rresp_o),
    .s_axil_rvalid_o(s_axil_rvalid_o), .s_axil_rready_i(s_axil_rready_i),
    .suspend_domain_pin_gpio_o(suspend_domain_pin_gpio_o),
    .wake_input_pins_gpio_o(wake_input_pins_gpio_o),
    .dedicated_pins_gpio_o(dedicated_pins_gpio_o),
    .card_data_gpio_mode_i(card_data_gpio_mode_i),
    .card_data_gpio_dout_i(card_data_gpio_dout_i),
    .card_data_func_out_i(card_data_func_out_i),
    .card_data_func_oe_i(card_data_func_oe_i),
    .card_data_pad_i(card_data_pad_i),
    .card_data_pad_o(card_data_pad_o),
    .card_data_pad_oe_o(card_data_pad_oe_o),
    .card_data_din_o(card_data_din_o)
  );
  always #12.5 clk_sys_i = ~clk_sys_i;
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // The whole run needs under a hundred cycles; a hung handshake ends here.
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // A non-zero lag holds the response ready low for that many cycles after the hand-off.
  task wr(input [11:0] a, input [31:0] d, input [1:0] er, input int lag = 0);
    @(posedge clk_sys_i);
    s_axil_awaddr_i <= a;
    s_axil_wdata_i <= d;
    s_axil_awvalid_i <= 1'b1;
    s_axil_wvalid_i <= 1'b1;
    s_axil_bready_i <= (lag == 0);
    fork
      begin
        do @(posedge clk_sys_i); while (!s_axil_awready_o);
        s_axil_awvalid_i <= 1'b0;
      end
      begin
        do @(posedge clk_sys_i); while (!s_axil_wready_o);
        s_axil_wvalid_i <= 1'b0;
      end
    join
    repeat (lag) @(posedge clk_sys_i);
    s_axil_bready_i <= 1'b1;
    do @(posedge clk_sys_i); while (!s_axil_bvalid_o);
    s_axil_bready_i <= 1'b0;
    `CHK("bresp", er, s_axil_bresp_o)
  endtask
  task rchk(input [11:0] a, input [31:0] e, input [1:0] er, input int lag = 0);
    @(posedge clk_sys_i);
    s_axil_araddr_i <= a;
    s_axil_arvalid_i <= 1'b1;
    s_axil_rready_i <= (lag == 0);
    do @(posedge clk_sys_i); while (!s_axil_arready_o);
    s_axil_arvalid_i <= 1'b0;
    repeat (lag) @(posedge clk_sys_i);
    s_axil_rready_i <= 1'b1;
    do @(posedge clk_sys_i); while (!s_axil_rvalid_o);
    s_axil_rready_i <= 1'b0;
    `CHK("rdata", e, s_axil_rdata_o)
    `CHK("rresp", er, s_axil_rresp_o)
  endtask
  // Undriven pins are compared only where the expected enable is high.
  task pads(input [7:0] m, input [7:0] eoe, input [7:0] eout);
    @(posedge clk_sys_i);
    card_data_gpio_mode_i <= m;
    card_data_gpio_dout_i <= 8'hff;
    card_data_func_out_i <= 8'hc3;
    card_data_func_oe_i <= 8'h3c;
    card_data_pad_i <= ~m;
    repeat (3) @(posedge clk_sys_i);
    `CHK("oe", eoe, card_data_pad_oe_o)
    `CHK("pad", eout, card_data_pad_o & eoe)
    `CHK("din", ~m, card_data_din_o)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rchk(12'h064, 32'h000000df, 2'h0);
    rchk(12'h068, 32'h00000000, 2'h0);
    `CHK("ded", 8'hdf, dedicated_pins_gpio_o)
    `CHK("wake", 5'h00, {suspend_domain_pin_gpio_o, wake_input_pins_gpio_o})
  endtask
  task t_select;
    wr(12'h064, 32'hffffffff, 2'h0);
    rchk(12'h064, 32'h003f00ff, 2'h0);
    `CHK("sel", 13'h1fff, sel_pins)
    wr(12'h064, 32'h00150081, 2'h0);
    rchk(12'h064, 32'h00150081, 2'h0);
    `CHK("sel", 13'h0581, sel_pins)
  endtask
  task t_dir;
    wr(12'h068, 32'hffffffa5, 2'h0);
    rchk(12'h068, 32'h000000a5, 2'h0);
    pads(8'h0f, 8'h35, 8'h05);
    pads(8'hf0, 8'hac, 8'ha0);
  endtask
  task t_unmap;
    wr(12'h06c, 32'hffffffff, 2'h2);
    rchk(12'h06c, 32'h00000000, 2'h2);
    rchk(12'h064, 32'h00150081, 2'h0);
    // Only byte lane 2 is enabled, so the suspend and wake selects clear alone.
    s_axil_wstrb_i <= 4'h4;
    wr(12'h064, 32'h00000000, 2'h0, 2);
    s_axil_wstrb_i <= 4'hf;
    rchk(12'h064, 32'h00000081, 2'h0, 2);
    `CHK("sel", 13'h0081, sel_pins)
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_select;
    t_dir;
    t_unmap;
    stop_test;
  end
endmodule // testbench
